// [common/fbg_pkg.sv]
// Purpose: shared constants and carrier types of the fieldbus serial configuration guard
// Assumes: 16-bit parameters reached by their fieldbus address, one clock of 40 MHz
// Notes:   persistent storage lives outside; reset loads the factory values
package fbg_pkg;

	// parameter addresses
	localparam logic [15:0] FBG_ADDR_LINE_RATE  = 16'h1606;
	localparam logic [15:0] FBG_ADDR_STATION    = 16'h1608;
	localparam logic [15:0] FBG_ADDR_FRAMING    = 16'h160a;
	localparam logic [15:0] FBG_ADDR_SER_GUARD  = 16'h160c;
	localparam logic [15:0] FBG_ADDR_SER_ORDER  = 16'h160e;
	localparam logic [15:0] FBG_ADDR_TCP_ORDER  = 16'h190a;
	localparam logic [15:0] FBG_ADDR_SCAN_GUARD = 16'h190e;

	// factory values
	localparam logic [15:0] FBG_RST_LINE_RATE  = 16'h4b00;
	localparam logic [15:0] FBG_RST_STATION    = 16'h0001;
	localparam logic [15:0] FBG_RST_FRAMING    = 16'h0002;
	localparam logic [15:0] FBG_RST_SER_GUARD  = 16'h0000;
	localparam logic [15:0] FBG_RST_SER_ORDER  = 16'h0000;
	localparam logic [15:0] FBG_RST_TCP_ORDER  = 16'h0000;
	localparam logic [15:0] FBG_RST_SCAN_GUARD = 16'h0000;

	// legal values
	localparam logic [15:0] FBG_STATION_MIN  = 16'h0001;
	localparam logic [15:0] FBG_STATION_MAX  = 16'h00f7;
	localparam logic [15:0] FBG_RATE_9600    = 16'h2580;
	localparam logic [15:0] FBG_RATE_19200   = 16'h4b00;
	localparam logic [15:0] FBG_RATE_38400   = 16'h9600;
	localparam logic [15:0] FBG_FRAME_8N1    = 16'h0001;
	localparam logic [15:0] FBG_FRAME_8E1    = 16'h0002;
	localparam logic [15:0] FBG_FRAME_8O1    = 16'h0003;
	localparam logic [15:0] FBG_FRAME_8N2    = 16'h0004;
	localparam logic [15:0] FBG_HIGH_WORD_FIRST = 16'h0000;
	localparam logic [15:0] FBG_LOW_WORD_FIRST  = 16'h0001;
	localparam logic [15:0] FBG_GUARD_OFF    = 16'h0000;
	localparam logic [15:0] FBG_GUARD_MAX_MS = 16'h2710;
	localparam int          FBG_DATA_BITS    = 8;

	// timing
	localparam int FBG_CLK_HZ       = 40_000_000;
	localparam int FBG_GUARD_TICK_MS = 1;
	localparam int FBG_CYC_PER_MS   = FBG_CLK_HZ / 1000 * FBG_GUARD_TICK_MS;
	localparam int FBG_PRE_W        = 17;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} fbg_par_req_t;

	typedef struct packed {
		logic        ack;
		logic        err;
		logic [15:0] rdata;
	} fbg_par_rsp_t;

	typedef struct packed {
		logic parity_en;
		logic parity_odd;
		logic two_stop;
	} fbg_frame_t;

	typedef struct packed {
		logic [15:0] first;
		logic [15:0] second;
	} fbg_words_t;

	typedef struct packed {
		logic                 armed;
		logic                 expired;
		logic [15:0]          ms;
		logic [FBG_PRE_W-1:0] pre;
	} fbg_guard_st_t;

	typedef struct packed {
		fbg_par_rsp_t rsp;
		logic [15:0]  station_address;
		logic [15:0]  line_rate;
		logic [15:0]  line_rate_act;
		logic [15:0]  framing;
		logic [15:0]  framing_act;
		logic [15:0]  ser_order;
		logic [15:0]  tcp_order;
		logic [15:0]  tcp_order_act;
		logic [15:0]  ser_guard;
		logic [15:0]  scan_guard;
		fbg_frame_t   frame;
		fbg_words_t   ser_words;
		fbg_words_t   tcp_words;
	} fbg_state_t;

endpackage

// [verilog/fbg_guard_timer.sv]
// Purpose: millisecond supervision timer for one guarded message stream
// Assumes: msg is a one-cycle pulse from logic on clk
// Notes:   timeout of zero switches the supervision off and clears its state
`timescale 1ns/1ps
module fbg_guard_timer
	import fbg_pkg::*;
#(
	parameter int CYC_PER_MS = FBG_CYC_PER_MS,
	parameter bit ARM_ON_MSG = 1'b1
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [15:0] timeout_ms,
	input  wire logic        msg,
	output logic             active,
	output logic             expired
);

	localparam logic [FBG_PRE_W-1:0] PRE_LAST = FBG_PRE_W'(CYC_PER_MS - 1);

	if (CYC_PER_MS < 2 || CYC_PER_MS > (1 << FBG_PRE_W)) begin : g_bad_cyc_per_ms
		$error("fbg_guard_timer: CYC_PER_MS out of range");
	end

	fbg_guard_st_t st;
	fbg_guard_st_t next_st;
	logic          expiring;

	assign expiring = st.armed && (st.pre == PRE_LAST) && ((st.ms + 16'h0001) >= timeout_ms);

	always_comb begin
		next_st = st;
		if (timeout_ms == FBG_GUARD_OFF) begin
			next_st = '0;
		end else if (msg && !expiring) begin
			// a message in the expiry cycle came too late: the expiry stands
			// every valid message restarts the count and clears a past expiry
			next_st.armed   = 1'b1;
			next_st.expired = 1'b0;
			next_st.ms      = 16'h0000;
			next_st.pre     = '0;
		end else if (st.armed) begin
			if (st.pre == PRE_LAST) begin
				next_st.pre = '0;
				// compare with >= so a timeout lowered mid-count still fires
				if ((st.ms + 16'h0001) >= timeout_ms) begin
					next_st.expired = 1'b1;
					next_st.armed   = 1'b0;
					next_st.ms      = 16'h0000;
				end else begin
					next_st.ms = st.ms + 16'h0001;
				end
			end else begin
				next_st.pre = st.pre + FBG_PRE_W'(1);
			end
		end else if (!ARM_ON_MSG && !st.expired) begin
			next_st.armed = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign active  = st.armed;
	assign expired = st.expired;

endmodule

// [verilog/fbg_config_guard.sv]
// Purpose: fieldbus communication settings and link supervision of the drive
// Assumes: parameter requests and message pulses come from logic on clk
// Notes:   reinit stands for the next power-on and applies the pending settings
//
// What this block does
// - station address limited to 1..247, immediate
// - line rate 9600/19200/38400, applied at power-on
// - framing codes 1..4, eight data bits, power-on
// - serial dword word order, applied immediately
// - tcp dword word order, applied at power-on
// - serial guard off at zero, timeout ms
// - scan guard off at zero, starts on message
// - after expiry wait for next scan message
`timescale 1ns/1ps
module fbg_config_guard
	import fbg_pkg::*;
#(
	parameter int CYC_PER_MS = FBG_CYC_PER_MS
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         reinit,
	input  fbg_par_req_t      par_req,
	output fbg_par_rsp_t      par_rsp,
	input  wire logic         serial_msg,
	input  wire logic         scan_msg,
	input  wire logic [31:0]  ser_dword,
	input  wire logic [31:0]  tcp_dword,
	output logic [15:0]       station_address,
	output logic [15:0]       serial_line_rate,
	output fbg_frame_t        char_frame,
	output logic              serial_low_word_first,
	output logic              tcp_low_word_first,
	output fbg_words_t        ser_words,
	output fbg_words_t        tcp_words,
	output logic              serial_guard_active,
	output logic              serial_guard_error,
	output logic              scan_guard_active,
	output logic              scan_guard_error
);

	// below two cycles the prescale cannot tell one millisecond from the next
	if (CYC_PER_MS < 2 || CYC_PER_MS > (1 << FBG_PRE_W)) begin : g_bad_cyc_per_ms
		$error("fbg_config_guard: CYC_PER_MS out of range");
	end

	fbg_state_t st;
	fbg_state_t next_st;

	function automatic fbg_frame_t decode_frame(input logic [15:0] code);
		fbg_frame_t f;
		f = '0;
		// all codes carry FBG_DATA_BITS data bits; only parity and stop vary
		case (code)
			FBG_FRAME_8E1: begin
				f.parity_en = 1'b1;
			end
			FBG_FRAME_8O1: begin
				f.parity_en  = 1'b1;
				f.parity_odd = 1'b1;
			end
			FBG_FRAME_8N2: begin
				f.two_stop = 1'b1;
			end
			default: begin
				f = '0;
			end
		endcase
		return f;
	endfunction

	function automatic fbg_words_t split_dword(input logic [31:0] v, input logic low_first);
		fbg_words_t w;
		if (low_first) begin
			w.first  = v[15:0];
			w.second = v[31:16];
		end else begin
			w.first  = v[31:16];
			w.second = v[15:0];
		end
		return w;
	endfunction

	logic rate_ok;
	logic station_ok;
	logic frame_ok;
	logic order_ok;
	logic guard_ok;

	always_comb begin
		rate_ok    = (par_req.wdata == FBG_RATE_9600) || (par_req.wdata == FBG_RATE_19200) ||
		             (par_req.wdata == FBG_RATE_38400);
		station_ok = (par_req.wdata >= FBG_STATION_MIN) &&
		             (par_req.wdata <= FBG_STATION_MAX);
		frame_ok   = (par_req.wdata >= FBG_FRAME_8N1) && (par_req.wdata <= FBG_FRAME_8N2);
		order_ok   = (par_req.wdata <= FBG_LOW_WORD_FIRST);
		guard_ok   = (par_req.wdata <= FBG_GUARD_MAX_MS);
	end

	always_comb begin
		next_st = st;
		next_st.rsp.ack   = par_req.wr | par_req.rd;
		next_st.rsp.err   = 1'b0;
		next_st.rsp.rdata = 16'h0000;
		if (par_req.wr) begin
			// a refused value leaves the stored setting untouched
			case (par_req.addr)
				FBG_ADDR_LINE_RATE: begin
					if (rate_ok) next_st.line_rate = par_req.wdata;
					else next_st.rsp.err = 1'b1;
				end
				FBG_ADDR_STATION: begin
					if (station_ok) next_st.station_address = par_req.wdata;
					else next_st.rsp.err = 1'b1;
				end
				FBG_ADDR_FRAMING: begin
					if (frame_ok) next_st.framing = par_req.wdata;
					else next_st.rsp.err = 1'b1;
				end
				FBG_ADDR_SER_GUARD: begin
					if (guard_ok) next_st.ser_guard = par_req.wdata;
					else next_st.rsp.err = 1'b1;
				end
				FBG_ADDR_SER_ORDER: begin
					if (order_ok) next_st.ser_order = par_req.wdata;
					else next_st.rsp.err = 1'b1;
				end
				FBG_ADDR_TCP_ORDER: begin
					if (order_ok) next_st.tcp_order = par_req.wdata;
					else next_st.rsp.err = 1'b1;
				end
				FBG_ADDR_SCAN_GUARD: begin
					if (guard_ok) next_st.scan_guard = par_req.wdata;
					else next_st.rsp.err = 1'b1;
				end
				default: begin
					next_st.rsp.err = 1'b1;
				end
			endcase
		end else if (par_req.rd) begin
			// reads show the stored value, which may differ from the active one
			case (par_req.addr)
				FBG_ADDR_LINE_RATE:  next_st.rsp.rdata = st.line_rate;
				FBG_ADDR_STATION:    next_st.rsp.rdata = st.station_address;
				FBG_ADDR_FRAMING:    next_st.rsp.rdata = st.framing;
				FBG_ADDR_SER_GUARD:  next_st.rsp.rdata = st.ser_guard;
				FBG_ADDR_SER_ORDER:  next_st.rsp.rdata = st.ser_order;
				FBG_ADDR_TCP_ORDER:  next_st.rsp.rdata = st.tcp_order;
				FBG_ADDR_SCAN_GUARD: next_st.rsp.rdata = st.scan_guard;
				default:             next_st.rsp.err = 1'b1;
			endcase
		end
		if (reinit) begin
			// a write in the same cycle is taken into the active copy as well
			next_st.line_rate_act = next_st.line_rate;
			next_st.framing_act   = next_st.framing;
			next_st.tcp_order_act = next_st.tcp_order;
			next_st.frame         = decode_frame(next_st.framing);
		end
		// order comes from the flop, so a new order shows on the words a cycle later
		next_st.ser_words = split_dword(ser_dword, st.ser_order[0]);
		next_st.tcp_words = split_dword(tcp_dword, st.tcp_order_act[0]);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st                 <= '0;
			st.station_address <= FBG_RST_STATION;
			st.line_rate       <= FBG_RST_LINE_RATE;
			st.line_rate_act   <= FBG_RST_LINE_RATE;
			st.framing         <= FBG_RST_FRAMING;
			st.framing_act     <= FBG_RST_FRAMING;
			// decoded from the factory code so the two can never disagree
			st.frame           <= decode_frame(FBG_RST_FRAMING);
			st.ser_order       <= FBG_RST_SER_ORDER;
			st.tcp_order       <= FBG_RST_TCP_ORDER;
			st.tcp_order_act   <= FBG_RST_TCP_ORDER;
			st.ser_guard       <= FBG_RST_SER_GUARD;
			st.scan_guard      <= FBG_RST_SCAN_GUARD;
		end else begin
			st <= next_st;
		end
	end

	// serial guard runs as soon as it is enabled; scan guard waits for traffic
	fbg_guard_timer #(
		.CYC_PER_MS (CYC_PER_MS),
		.ARM_ON_MSG (1'b0)
	) u_serial_guard (
		.clk        (clk),
		.srst       (srst),
		.timeout_ms (st.ser_guard),
		.msg        (serial_msg),
		.active     (serial_guard_active),
		.expired    (serial_guard_error)
	);

	fbg_guard_timer #(
		.CYC_PER_MS (CYC_PER_MS),
		.ARM_ON_MSG (1'b1)
	) u_scan_guard (
		.clk        (clk),
		.srst       (srst),
		.timeout_ms (st.scan_guard),
		.msg        (scan_msg),
		.active     (scan_guard_active),
		.expired    (scan_guard_error)
	);

	assign par_rsp               = st.rsp;
	assign station_address       = st.station_address;
	assign serial_line_rate      = st.line_rate_act;
	assign char_frame            = st.frame;
	assign serial_low_word_first = st.ser_order[0];
	assign tcp_low_word_first    = st.tcp_order_act[0];
	assign ser_words             = st.ser_words;
	assign tcp_words             = st.tcp_words;

endmodule

// [bench/fbg_config_guard_monitor.sv]
// Purpose: port checker of the config guard
// Assumes: one clock, srst synchronous active high
// Notes:   guard counts are judged by the bench
`timescale 1ns/1ps
module fbg_config_guard_monitor
	import fbg_pkg::*;
#(
	parameter int CYC_PER_MS = FBG_CYC_PER_MS
) (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        reinit,
	input fbg_par_req_t     par_req,
	input wire logic        serial_msg,
	input wire logic        scan_msg,
	input wire logic [31:0] ser_dword,
	input wire logic [31:0] tcp_dword,
	input wire logic [15:0] station_address,
	input wire logic [15:0] serial_line_rate,
	input fbg_frame_t       char_frame,
	input wire logic        serial_low_word_first,
	input wire logic        tcp_low_word_first,
	input fbg_words_t       ser_words,
	input fbg_words_t       tcp_words,
	input wire logic        serial_guard_error,
	input wire logic        scan_guard_active,
	input wire logic        scan_guard_error
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	AST_STATION_RANGE: assert property (station_address inside {[1:247]})
		else $error("station address out of range");
	AST_STATION_NOW: assert property (par_req.wr && par_req.addr == FBG_ADDR_STATION
		&& par_req.wdata inside {[1:247]} |=> station_address == $past(par_req.wdata))
		else $error("station write not applied");
	AST_RATE_HOLD: assert property (!reinit |=> $stable(serial_line_rate))
		else $error("line rate moved without power-on");
	AST_FRAME_HOLD: assert property (!reinit |=> $stable(char_frame))
		else $error("framing moved without power-on");
	AST_TCP_HOLD: assert property (!reinit |=> $stable(tcp_low_word_first))
		else $error("tcp order moved without power-on");
	// the first edge after reset still sees reset-time inputs in past
	AST_SER_SPLIT: assert property (!$past(srst) |-> ser_words ==
		($past(serial_low_word_first) ? {$past(ser_dword[15:0]), $past(ser_dword[31:16])}
		: $past(ser_dword))) else $error("serial word split wrong");
	AST_TCP_SPLIT: assert property (!$past(srst) |-> tcp_words ==
		($past(tcp_low_word_first) ? {$past(tcp_dword[15:0]), $past(tcp_dword[31:16])}
		: $past(tcp_dword))) else $error("tcp word split wrong");
	AST_SCAN_ARM: assert property ($rose(scan_guard_active) |-> $past(scan_msg))
		else $error("scan guard armed without message");
	AST_SCAN_IDLE: assert property (scan_guard_error |-> !scan_guard_active)
		else $error("scan guard active after expiry");
	AST_RESTART: assert property (serial_guard_error && serial_msg |=> !serial_guard_error)
		else $error("message did not restart guard");
endmodule

// [bench/fbg_master_model.sv]
// Purpose: fieldbus master sending guarded message streams
// Assumes: gaps change by nonblocking assignment on the falling edge
// Notes:   a gap of zero keeps the stream silent
`timescale 1ns/1ps
module fbg_master_model (
	input  wire logic       clk,
	input  wire logic [7:0] ser_gap,
	input  wire logic [7:0] scan_gap,
	output logic            serial_msg,
	output logic            scan_msg
);
	logic [7:0] ser_cnt = 8'h00;
	logic [7:0] scan_cnt = 8'h00;
	initial serial_msg = 1'b0;
	initial scan_msg = 1'b0;
	// gap below the timeout keeps the drive supervised
	always @(negedge clk) begin
		serial_msg <= ser_gap != 8'h00 && ser_cnt == 8'h00;
		scan_msg <= scan_gap != 8'h00 && scan_cnt == 8'h00;
		ser_cnt <= (ser_cnt + 8'h01 >= ser_gap) ? 8'h00 : ser_cnt + 8'h01;
		scan_cnt <= (scan_cnt + 8'h01 >= scan_gap) ? 8'h00 : scan_cnt + 8'h01;
	end
endmodule

// [bench/fbg_config_guard_tb.sv]
// Purpose: self-checking bench of the config guard
// Assumes: inputs change on the falling edge
// Notes:   CYC_PER_MS shortened to 4 so guard times stay short
`timescale 1ns/1ps
module fbg_config_guard_tb import fbg_pkg::*;;
	localparam int CYC_PER_MS = 4;
	logic         clk = 1'b0;
	logic         srst = 1'b1;
	logic         reinit = 1'b0;
	fbg_par_req_t par_req = '0;
	fbg_par_rsp_t par_rsp;
	logic         serial_msg, scan_msg;
	logic [31:0]  ser_dword = 32'h12345678;
	logic [31:0]  tcp_dword = 32'h9abcdef0;
	logic [15:0]  station_address, serial_line_rate;
	fbg_frame_t   char_frame;
	logic         serial_low_word_first, tcp_low_word_first;
	fbg_words_t   ser_words, tcp_words;
	logic         serial_guard_active, serial_guard_error, scan_guard_active, scan_guard_error;
	logic [7:0]   ser_gap = 8'h00;
	logic [7:0]   scan_gap = 8'h00;
	int           mismatches = 0;
	int           n_checks = 0;
	int           cycles = 0;
	always #12.5 clk = ~clk;
	fbg_config_guard #(.CYC_PER_MS(CYC_PER_MS)) u_dut (
		.clk                   (clk),
		.srst                  (srst),
		.reinit                (reinit),
		.par_req               (par_req),
		.par_rsp               (par_rsp),
		.serial_msg            (serial_msg),
		.scan_msg              (scan_msg),
		.ser_dword             (ser_dword),
		.tcp_dword             (tcp_dword),
		.station_address       (station_address),
		.serial_line_rate      (serial_line_rate),
		.char_frame            (char_frame),
		.serial_low_word_first (serial_low_word_first),
		.tcp_low_word_first    (tcp_low_word_first),
		.ser_words             (ser_words),
		.tcp_words             (tcp_words),
		.serial_guard_active   (serial_guard_active),
		.serial_guard_error    (serial_guard_error),
		.scan_guard_active     (scan_guard_active),
		.scan_guard_error      (scan_guard_error)
	);
	fbg_master_model u_master (
		.clk        (clk),
		.ser_gap    (ser_gap),
		.scan_gap   (scan_gap),
		.serial_msg (serial_msg),
		.scan_msg   (scan_msg)
	);
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			results();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// write data is not answered, so rdata is masked on writes
	task automatic access(input logic w, input logic [15:0] a, d, input logic e,
		input logic [15:0] r);
		par_req <= '{w, ~w, a, d};
		@(negedge clk);
		par_req <= '0;
		check({par_rsp.ack, par_rsp.err, w ? 16'h0000 : par_rsp.rdata}, {1'b1, e, r});
		@(negedge clk);
	endtask
	task automatic power_on();
		reinit <= 1'b1;
		@(negedge clk);
		reinit <= 1'b0;
		@(negedge clk);
	endtask
	task automatic t_reset();
		logic [15:0] a[7] = '{FBG_ADDR_LINE_RATE, FBG_ADDR_STATION, FBG_ADDR_FRAMING,
			FBG_ADDR_SER_GUARD, FBG_ADDR_SER_ORDER, FBG_ADDR_TCP_ORDER, FBG_ADDR_SCAN_GUARD};
		logic [15:0] v[7] = '{FBG_RST_LINE_RATE, FBG_RST_STATION, FBG_RST_FRAMING,
			FBG_RST_SER_GUARD, FBG_RST_SER_ORDER, FBG_RST_TCP_ORDER, FBG_RST_SCAN_GUARD};
		for (int i = 0; i < 7; i++)
			access(1'b0, a[i], 16'h0000, 1'b0, v[i]);
		access(1'b0, 16'h1600, 16'h0000, 1'b1, 16'h0000);
		check(char_frame, 32'h4);
	endtask
	task automatic t_station();
		access(1'b1, FBG_ADDR_STATION, 16'h0000, 1'b1, 16'h0000);
		access(1'b1, FBG_ADDR_STATION, 16'h00f8, 1'b1, 16'h0000);
		access(1'b1, FBG_ADDR_STATION, 16'h00f7, 1'b0, 16'h0000);
		check(station_address, 32'hf7);
		access(1'b0, FBG_ADDR_STATION, 16'h0000, 1'b0, 16'h00f7);
	endtask
	task automatic t_rate_frame();
		logic [15:0] r[3] = '{FBG_RATE_9600, FBG_RATE_38400, FBG_RATE_19200};
		logic [2:0] f[4] = '{3'b000, 3'b100, 3'b110, 3'b001};
		for (int i = 0; i < 3; i++) begin
			access(1'b1, FBG_ADDR_LINE_RATE, r[i], 1'b0, 16'h0000);
			check(serial_line_rate, i == 0 ? FBG_RST_LINE_RATE : r[(i + 2) % 3]);
			power_on();
			check(serial_line_rate, r[i]);
		end
		access(1'b1, FBG_ADDR_LINE_RATE, 16'h04b0, 1'b1, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			access(1'b1, FBG_ADDR_FRAMING, 16'(i + 1), 1'b0, 16'h0000);
			power_on();
			check(char_frame, f[i]);
		end
		access(1'b1, FBG_ADDR_FRAMING, 16'h0005, 1'b1, 16'h0000);
		power_on();
		check({serial_line_rate, 13'h0, char_frame}, {FBG_RATE_19200, 16'h1});
	endtask
	task automatic t_order();
		access(1'b1, FBG_ADDR_SER_ORDER, 16'h0001, 1'b0, 16'h0000);
		check(ser_words, 32'h56781234);
		access(1'b1, FBG_ADDR_TCP_ORDER, 16'h0001, 1'b0, 16'h0000);
		check(tcp_words, 32'h9abcdef0);
		check({serial_low_word_first, tcp_low_word_first}, 32'h2);
		power_on();
		check(tcp_words, 32'hdef09abc);
		check({serial_low_word_first, tcp_low_word_first}, 32'h3);
	endtask
	task automatic t_guard();
		access(1'b1, FBG_ADDR_SER_GUARD, 16'h0001, 1'b0, 16'h0000);
		repeat (12) @(negedge clk);
		check({serial_guard_active, serial_guard_error}, 32'h1);
		ser_gap <= 8'h02;
		repeat (30) @(negedge clk);
		check({serial_guard_active, serial_guard_error}, 32'h2);
		ser_gap <= 8'h00;
		access(1'b1, FBG_ADDR_SER_GUARD, FBG_GUARD_OFF, 1'b0, 16'h0000);
		repeat (20) @(negedge clk);
		check({serial_guard_active, serial_guard_error}, 32'h0);
		access(1'b1, FBG_ADDR_SCAN_GUARD, 16'h2711, 1'b1, 16'h0000);
		access(1'b1, FBG_ADDR_SCAN_GUARD, 16'h0002, 1'b0, 16'h0000);
		for (int k = 0; k < 2; k++) begin
			repeat (20) @(negedge clk);
			check({scan_guard_active, scan_guard_error}, k ? 32'h1 : 32'h0);
			scan_gap <= 8'h01;
			@(negedge clk);
			scan_gap <= 8'h00;
			repeat (8) @(negedge clk);
			check({scan_guard_active, scan_guard_error}, 32'h2);
			@(negedge clk);
			check({scan_guard_active, scan_guard_error}, 32'h1);
		end
	endtask
	initial begin
		repeat (3) @(negedge clk);
		srst <= 1'b0;
		@(negedge clk);
		t_reset();
		t_station();
		t_rate_frame();
		t_order();
		t_guard();
		results();
	end
endmodule
bind fbg_config_guard fbg_config_guard_monitor #(.CYC_PER_MS(CYC_PER_MS)) u_mon (
	.clk                   (clk),
	.srst                  (srst),
	.reinit                (reinit),
	.par_req               (par_req),
	.serial_msg            (serial_msg),
	.scan_msg              (scan_msg),
	.ser_dword             (ser_dword),
	.tcp_dword             (tcp_dword),
	.station_address       (station_address),
	.serial_line_rate      (serial_line_rate),
	.char_frame            (char_frame),
	.serial_low_word_first (serial_low_word_first),
	.tcp_low_word_first    (tcp_low_word_first),
	.ser_words             (ser_words),
	.tcp_words             (tcp_words),
	.serial_guard_error    (serial_guard_error),
	.scan_guard_active     (scan_guard_active),
	.scan_guard_error      (scan_guard_error)
);
